/* File: hw/dpd_pkg.sv */
// Purpose: shared constants for the panel scan and frame-buffer port
// Assumes: 16-bit banks of 256K words, 12-bit scan buses
// Notes: line and frame sizes are plain defaults for a small panel
package dpd_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 10;
   localparam int WADDR_W = 18;
   localparam int SCAN_W = 12;
   localparam int ROW_LSB = 8;
   localparam int MODE_TFT_BIT = 0;
   localparam int MODE_24_BIT = 1;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] BE_BOTH = 2'h3;
   localparam logic [9:0] LINE_WORDS = 10'h028;
   localparam logic [9:0] HALF_LINES = 10'h0f0;
   localparam logic [17:0] FRAME_WORDS = 18'h02580;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage

/* File: hw/dpd_bank.sv */
// Purpose: one EDO bank sequencer: row, column, precharge per request
// Assumes: step marks a pixel clock edge; each phase lasts one step
// Notes: pins come from flops computed from the next state
`timescale 1ns/1ps
module dpd_bank
   import dpd_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic reset_n, // synchronous reset
   input wire logic step, // pixel clock edge pulse
   input wire logic req_valid, // access request
   input wire logic req_write, // 1 write, 0 read
   input wire logic [WADDR_W-1:0] req_addr, // word address
   input wire logic [1:0] req_be, // byte lanes, bit 1 upper
   input wire logic [DATA_W-1:0] req_wdata, // write data
   output logic req_ready, // request taken this cycle
   output logic rd_valid, // read word pulse
   output logic [DATA_W-1:0] rd_data, // read word
   output logic [ADDR_W-1:0] dram_addr, // multiplexed address
   input wire logic [DATA_W-1:0] dram_dq_in, // data pins in
   output logic [DATA_W-1:0] dram_dq_out, // data pins out
   output logic dram_dq_oe_n, // low while driving data
   output logic row_strobe_n, // row strobe
   output logic hi_col_strobe_n, // upper byte column strobe
   output logic lo_col_strobe_n, // lower byte column strobe
   output logic out_en_n, // dram output enable
   output logic write_strobe_n // dram write enable
);
   typedef enum logic [1:0] {B_IDLE, B_ROW, B_COL, B_PRE} dpd_bank_state_t;
   dpd_bank_state_t state, next_state;
   logic [WADDR_W-1:0] addr_q, next_addr_q;
   logic wr_q, next_wr_q;
   logic [1:0] be_q, next_be_q;
   logic [DATA_W-1:0] next_dram_dq_out, next_rd_data;
   logic [DATA_W-1:0] dq_s1, dq_s2;
   logic next_rd_valid, next_row, next_hi, next_lo, next_oe, next_we, next_dq_oe_n;
   logic [ADDR_W-1:0] next_dram_addr;

   assign req_ready = (state == B_IDLE) && step;

   always_comb begin
      next_state = state;
      next_addr_q = addr_q;
      next_wr_q = wr_q;
      next_be_q = be_q;
      next_dram_dq_out = dram_dq_out;
      next_rd_data = rd_data;
      next_rd_valid = 1'b0;
      case (state)
         B_IDLE: begin
            if (req_valid && step) begin
               next_state = B_ROW;
               next_addr_q = req_addr;
               next_wr_q = req_write;
               next_be_q = req_be;
               next_dram_dq_out = req_wdata;
            end
         end
         B_ROW: begin
            if (step) begin
               next_state = B_COL;
            end
         end
         B_COL: begin
            if (step) begin
               next_state = B_PRE;
               if (!wr_q) begin
                  next_rd_data = dq_s2;
                  next_rd_valid = 1'b1;
               end
            end
         end
         B_PRE: begin
            if (step) begin
               next_state = B_IDLE;
            end
         end
         default: next_state = B_IDLE;
      endcase
      next_row = !((next_state == B_ROW) || (next_state == B_COL));
      next_dram_addr = (next_state == B_ROW) ? next_addr_q[WADDR_W-1:ROW_LSB] :
         {2'h0, next_addr_q[ROW_LSB-1:0]};
      next_hi = !((next_state == B_COL) && next_be_q[1]);
      next_lo = !((next_state == B_COL) && next_be_q[0]);
      next_oe = !((next_state == B_COL) && !next_wr_q);
      next_we = !((next_state == B_COL) && next_wr_q);
      next_dq_oe_n = !((next_state == B_COL) && next_wr_q);
   end

   always_ff @(posedge mclk) begin
      dq_s1 <= dram_dq_in;
      dq_s2 <= dq_s1;
      if (!reset_n) begin
         state <= B_IDLE;
         addr_q <= '0;
         wr_q <= 1'b0;
         be_q <= 2'h0;
         dram_dq_out <= '0;
         rd_data <= '0;
         rd_valid <= 1'b0;
         dram_addr <= '0;
         row_strobe_n <= 1'b1;
         hi_col_strobe_n <= 1'b1;
         lo_col_strobe_n <= 1'b1;
         out_en_n <= 1'b1;
         write_strobe_n <= 1'b1;
         dram_dq_oe_n <= 1'b1;
      end else begin
         state <= next_state;
         addr_q <= next_addr_q;
         wr_q <= next_wr_q;
         be_q <= next_be_q;
         dram_dq_out <= next_dram_dq_out;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
         dram_addr <= next_dram_addr;
         row_strobe_n <= next_row;
         hi_col_strobe_n <= next_hi;
         lo_col_strobe_n <= next_lo;
         out_en_n <= next_oe;
         write_strobe_n <= next_we;
         dram_dq_oe_n <= next_dq_oe_n;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   idle_strobes_high_a: assert property ((state == B_IDLE) |-> (row_strobe_n && hi_col_strobe_n
      && lo_col_strobe_n && out_en_n && write_strobe_n)) else $error("strobe low while idle");
   col_under_row_a: assert property ((!hi_col_strobe_n || !lo_col_strobe_n) |-> !row_strobe_n)
      else $error("column strobe without row strobe");
   row_addr_out_a: assert property ($fell(row_strobe_n) |-> dram_addr == addr_q[WADDR_W-1:ROW_LSB])
      else $error("row address wrong at row strobe");
   oe_we_excl_a: assert property (!(out_en_n == 1'b0 && write_strobe_n == 1'b0))
      else $error("output enable and write enable both low");
   drive_on_write_a: assert property (!dram_dq_oe_n |-> (!write_strobe_n && !row_strobe_n))
      else $error("data driven outside write");
   read_done_a: assert property ($rose(out_en_n) && !wr_q |-> rd_valid)
      else $error("read ended without data");
   bank_write_c: cover property ($fell(write_strobe_n));
endmodule

/* File: hw/dstn_panel_and_dram_port.sv */
// Purpose: panel scan output and dual-bank frame-buffer read/write port
// Assumes: pixel_input_clock slower than mclk/4, mode_select quasi-static
// Notes: writes take priority over display fetch; fetch stalls the scan
`timescale 1ns/1ps
module dstn_panel_and_dram_port
   import dpd_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic pixel_input_clock, // pixel clock pin
   input wire logic power_request_in, // panel voltage request
   input wire logic control_request_in, // panel control request
   input wire logic [1:0] mode_select, // scan format select
   input wire logic wr_valid, // frame-buffer write request
   output logic wr_ready, // write taken
   input wire logic wr_bank, // 0 bank a, 1 bank b
   input wire logic [WADDR_W-1:0] wr_addr, // write word address
   input wire logic [1:0] wr_be, // write byte lanes
   input wire logic [DATA_W-1:0] wr_data, // write word
   output logic line_latch_pulse, // line end pulse
   output logic panel_shift_clock, // panel data clock
   output logic frame_start_marker, // frame end pulse
   output logic [SCAN_W-1:0] upper_half_data, // upper half scan data
   output logic [SCAN_W-1:0] lower_half_data, // lower half scan data
   output logic panel_disable_n, // low disables the panel
   output logic panel_power_enable, // panel supply switch
   output logic panel_contrast_enable, // contrast bias switch
   output logic [ADDR_W-1:0] bank_a_addr, // bank a address
   input wire logic [DATA_W-1:0] bank_a_data_in, // bank a data in
   output logic [DATA_W-1:0] bank_a_data_out, // bank a data out
   output logic bank_a_data_oe_n, // bank a drive enable, low drives
   output logic bank_a_row_strobe_n, // bank a row strobe
   output logic bank_a_hi_col_strobe_n, // bank a upper column strobe
   output logic bank_a_lo_col_strobe_n, // bank a lower column strobe
   output logic bank_a_out_en_n, // bank a output enable
   output logic bank_a_write_strobe_n, // bank a write enable
   output logic [ADDR_W-1:0] bank_b_addr, // bank b address
   input wire logic [DATA_W-1:0] bank_b_data_in, // bank b data in
   output logic [DATA_W-1:0] bank_b_data_out, // bank b data out
   output logic bank_b_data_oe_n, // bank b drive enable, low drives
   output logic bank_b_row_strobe_n, // bank b row strobe
   output logic bank_b_hi_col_strobe_n, // bank b upper column strobe
   output logic bank_b_lo_col_strobe_n, // bank b lower column strobe
   output logic bank_b_out_en_n, // bank b output enable
   output logic bank_b_write_strobe_n // bank b write enable
);
   typedef enum logic {F_IDLE, F_READ} dpd_fetch_state_t;
   typedef enum logic [2:0] {P_OFF, P_DATA, P_SHIFT, P_LATCH, P_END} dpd_panel_state_t;

   function automatic logic [SCAN_W-1:0] dpd_fmt(input logic [1:0] m, input logic [DATA_W-1:0] w);
      if (m[MODE_TFT_BIT]) begin
         dpd_fmt = {4'h0, w[7:0]};
      end else if (m[MODE_24_BIT]) begin
         dpd_fmt = w[SCAN_W-1:0];
      end else begin
         dpd_fmt = {4'h0, w[7:0]};
      end
   endfunction

   logic pclk_s1, pclk_s2, pclk_s3, pwr_s1, pwr_s2, ctl_s1, ctl_s2, step;
   logic [1:0] mode_s1, mode_s2, mode;
   // sync chains and edge finder
   always_ff @(posedge mclk) begin
      pclk_s1 <= pixel_input_clock;
      pclk_s2 <= pclk_s1;
      // no reset here: a pin held high at release must not look like an edge
      pclk_s3 <= pclk_s2;
      pwr_s1 <= power_request_in;
      ctl_s1 <= control_request_in;
      mode_s1 <= mode_select;
      if (!reset_n) begin
         pwr_s2 <= 1'b0;
         ctl_s2 <= 1'b0;
         mode_s2 <= MODE_RESET;
         mode <= MODE_RESET;
      end else begin
         pwr_s2 <= pwr_s1;
         ctl_s2 <= ctl_s1;
         mode_s2 <= mode_s1;
         mode <= mode_s2;
      end
   end
   assign step = pclk_s2 && !pclk_s3;

   // panel enables follow the controller's requests
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         panel_power_enable <= 1'b0;
         panel_contrast_enable <= 1'b0;
         panel_disable_n <= 1'b0;
      end else begin
         panel_power_enable <= pwr_s2;
         panel_contrast_enable <= pwr_s2 && ctl_s2;
         panel_disable_n <= pwr_s2 && ctl_s2;
      end
   end

   // fetch: read one word from each bank, push the pair
   dpd_fetch_state_t fstate, next_fstate;
   logic [WADDR_W-1:0] faddr, next_faddr;
   logic a_sent, b_sent, got_a, got_b, next_a_sent, next_b_sent, next_got_a, next_got_b;
   logic [DATA_W-1:0] word_a, word_b, next_word_a, next_word_b;
   logic a_valid, a_ready, b_valid, b_ready, a_rd, b_rd, a_write, b_write;
   logic [DATA_W-1:0] a_rdata, b_rdata;
   logic in_valid, in_ready, out_valid, out_ready;
   logic [2*DATA_W-1:0] fifo_d0, fifo_d1, next_d0, next_d1;
   logic [1:0] fifo_cnt, next_cnt;

   assign a_write = (fstate == F_IDLE) && wr_valid && !wr_bank;
   assign b_write = (fstate == F_IDLE) && wr_valid && wr_bank;
   assign a_valid = a_write || ((fstate == F_READ) && !a_sent);
   assign b_valid = b_write || ((fstate == F_READ) && !b_sent);
   assign wr_ready = wr_bank ? (b_write && b_ready) : (a_write && a_ready);
   assign in_valid = (fstate == F_READ) && got_a && got_b;
   assign in_ready = fifo_cnt != FIFO_DEPTH;
   assign out_valid = fifo_cnt != 2'h0;

   always_comb begin
      next_fstate = fstate;
      next_faddr = faddr;
      next_a_sent = a_sent || (a_valid && a_ready && !a_write);
      next_b_sent = b_sent || (b_valid && b_ready && !b_write);
      next_got_a = got_a || a_rd;
      next_got_b = got_b || b_rd;
      next_word_a = a_rd ? a_rdata : word_a;
      next_word_b = b_rd ? b_rdata : word_b;
      case (fstate)
         F_IDLE: begin
            next_a_sent = 1'b0;
            next_b_sent = 1'b0;
            next_got_a = 1'b0;
            next_got_b = 1'b0;
            if (!wr_valid && in_ready && ctl_s2) begin
               next_fstate = F_READ;
            end
         end
         F_READ: begin
            if (in_valid && in_ready) begin
               next_fstate = F_IDLE;
               next_faddr = (faddr == FRAME_WORDS - 18'h00001) ? 18'h00000 : faddr + 18'h00001;
            end
         end
         default: next_fstate = F_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         fstate <= F_IDLE;
         faddr <= '0;
         a_sent <= 1'b0;
         b_sent <= 1'b0;
         got_a <= 1'b0;
         got_b <= 1'b0;
         word_a <= '0;
         word_b <= '0;
      end else begin
         fstate <= next_fstate;
         faddr <= next_faddr;
         a_sent <= next_a_sent;
         b_sent <= next_b_sent;
         got_a <= next_got_a;
         got_b <= next_got_b;
         word_a <= next_word_a;
         word_b <= next_word_b;
      end
   end

   // banks run on their own sequencers
   dpd_bank u_bank_a (
      .mclk(mclk), .reset_n(reset_n), .step(step), .req_valid(a_valid), .req_write(a_write),
      .req_addr(a_write ? wr_addr : faddr), .req_be(a_write ? wr_be : BE_BOTH), .req_wdata(wr_data),
      .req_ready(a_ready), .rd_valid(a_rd), .rd_data(a_rdata), .dram_addr(bank_a_addr),
      .dram_dq_in(bank_a_data_in), .dram_dq_out(bank_a_data_out), .dram_dq_oe_n(bank_a_data_oe_n),
      .row_strobe_n(bank_a_row_strobe_n), .hi_col_strobe_n(bank_a_hi_col_strobe_n),
      .lo_col_strobe_n(bank_a_lo_col_strobe_n), .out_en_n(bank_a_out_en_n),
      .write_strobe_n(bank_a_write_strobe_n));
   dpd_bank u_bank_b (
      .mclk(mclk), .reset_n(reset_n), .step(step), .req_valid(b_valid), .req_write(b_write),
      .req_addr(b_write ? wr_addr : faddr), .req_be(b_write ? wr_be : BE_BOTH), .req_wdata(wr_data),
      .req_ready(b_ready), .rd_valid(b_rd), .rd_data(b_rdata), .dram_addr(bank_b_addr),
      .dram_dq_in(bank_b_data_in), .dram_dq_out(bank_b_data_out), .dram_dq_oe_n(bank_b_data_oe_n),
      .row_strobe_n(bank_b_row_strobe_n), .hi_col_strobe_n(bank_b_hi_col_strobe_n),
      .lo_col_strobe_n(bank_b_lo_col_strobe_n), .out_en_n(bank_b_out_en_n),
      .write_strobe_n(bank_b_write_strobe_n));

   // two-entry buffer between fetch and scan
   always_comb begin
      next_d0 = fifo_d0;
      next_d1 = fifo_d1;
      next_cnt = fifo_cnt;
      case ({in_valid && in_ready, out_valid && out_ready})
         2'h2: begin
            if (fifo_cnt == 2'h0) begin
               next_d0 = {word_a, word_b};
            end else begin
               next_d1 = {word_a, word_b};
            end
            next_cnt = fifo_cnt + 2'h1;
         end
         2'h1: begin
            next_d0 = fifo_d1;
            next_cnt = fifo_cnt - 2'h1;
         end
         2'h3: begin
            next_d0 = (fifo_cnt == 2'h1) ? {word_a, word_b} : fifo_d1;
            next_d1 = {word_a, word_b};
         end
         default: next_cnt = fifo_cnt;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         fifo_d0 <= '0;
         fifo_d1 <= '0;
         fifo_cnt <= 2'h0;
      end else begin
         fifo_d0 <= next_d0;
         fifo_d1 <= next_d1;
         fifo_cnt <= next_cnt;
      end
   end

   // panel scan: data, shift high, repeat; latch at line end
   dpd_panel_state_t pstate, next_pstate;
   logic [9:0] h_cnt, v_cnt, next_h, next_v;
   logic next_shift, next_latch, next_flm;
   logic [SCAN_W-1:0] next_upper, next_lower;

   assign out_ready = (pstate == P_DATA) && step;

   always_comb begin
      next_pstate = pstate;
      next_h = h_cnt;
      next_v = v_cnt;
      next_shift = panel_shift_clock;
      next_latch = line_latch_pulse;
      next_flm = frame_start_marker;
      next_upper = upper_half_data;
      next_lower = lower_half_data;
      if (step) begin
         case (pstate)
            P_OFF: begin
               next_h = 10'h000;
               next_v = 10'h000;
               if (ctl_s2) begin
                  next_pstate = P_DATA;
               end
            end
            P_DATA: begin
               next_shift = 1'b0;
               if (out_valid) begin
                  next_upper = dpd_fmt(mode, fifo_d0[2*DATA_W-1:DATA_W]);
                  next_lower = dpd_fmt(mode, fifo_d0[DATA_W-1:0]);
                  next_pstate = P_SHIFT;
               end
            end
            P_SHIFT: begin
               next_shift = 1'b1;
               next_h = (h_cnt == LINE_WORDS - 10'h001) ? 10'h000 : h_cnt + 10'h001;
               next_pstate = (h_cnt == LINE_WORDS - 10'h001) ? P_LATCH : P_DATA;
            end
            P_LATCH: begin
               next_shift = 1'b0;
               next_latch = 1'b1;
               next_flm = (v_cnt == HALF_LINES - 10'h001);
               next_upper = '0;
               next_lower = '0;
               next_v = (v_cnt == HALF_LINES - 10'h001) ? 10'h000 : v_cnt + 10'h001;
               next_pstate = P_END;
            end
            P_END: begin
               next_latch = 1'b0;
               next_flm = 1'b0;
               next_pstate = ctl_s2 ? P_DATA : P_OFF;
            end
            default: next_pstate = P_OFF;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pstate <= P_OFF;
         h_cnt <= 10'h000;
         v_cnt <= 10'h000;
         panel_shift_clock <= 1'b0;
         line_latch_pulse <= 1'b0;
         frame_start_marker <= 1'b0;
         upper_half_data <= '0;
         lower_half_data <= '0;
      end else begin
         pstate <= next_pstate;
         h_cnt <= next_h;
         v_cnt <= next_v;
         panel_shift_clock <= next_shift;
         line_latch_pulse <= next_latch;
         frame_start_marker <= next_flm;
         upper_half_data <= next_upper;
         lower_half_data <= next_lower;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   latch_data_zero_a: assert property (line_latch_pulse |-> (upper_half_data == '0 && lower_half_data == '0))
      else $error("scan data not zero during latch");
   latch_width_a: assert property ($rose(line_latch_pulse) |-> line_latch_pulse[*4])
      else $error("latch pulse too short");
   shift_data_stable_a: assert property ($rose(panel_shift_clock) |-> ($stable(upper_half_data)
      && $stable(lower_half_data))[*4]) else $error("scan data moved under shift clock");
   marker_with_latch_a: assert property (frame_start_marker |-> line_latch_pulse)
      else $error("frame marker outside latch");
   mode_reset_zero_a: assert property ($past(!reset_n) |-> mode == MODE_RESET)
      else $error("mode not zero after reset");
   disable_follows_a: assert property (!ctl_s2 |=> !panel_disable_n)
      else $error("panel not disabled without control request");
   power_follows_a: assert property ($rose(pwr_s2) |=> panel_power_enable)
      else $error("power enable did not follow request");
   contrast_needs_power_a: assert property (panel_contrast_enable |-> panel_power_enable)
      else $error("contrast without supply");
   step_single_a: assert property (step |=> !step)
      else $error("pixel edge pulse longer than one cycle");
   buffer_bound_a: assert property (fifo_cnt <= FIFO_DEPTH)
      else $error("buffer count overflow");
   frame_c: cover property (frame_start_marker);
   line_c: cover property ($rose(line_latch_pulse));
   buffer_full_c: cover property (fifo_cnt == FIFO_DEPTH);
   write_taken_c: cover property (wr_valid && wr_ready);
endmodule

/* File: dv/dpd_dram_model.sv */
// Purpose: behavioural EDO bank on the far side of one frame-buffer port
// Assumes: low eight address bits pick the word; unwritten words read zero
// Notes: a released bus shows the inverse of the last read word
`timescale 1ns/1ps
module dpd_dram_model (
   input wire logic mclk, // system clock
   input wire logic [9:0] addr, // multiplexed address
   input wire logic [15:0] dq_out, // data from the port
   input wire logic dq_oe_n, // low while the port drives
   input wire logic row_n, // row strobe
   input wire logic hi_n, // upper column strobe
   input wire logic lo_n, // lower column strobe
   input wire logic oe_n, // output enable
   input wire logic we_n, // write enable
   output logic [15:0] dq_in // data to the port
);
   logic [15:0] mem [0:255];
   logic [15:0] last = 16'h0000;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
   always @(posedge mclk) begin
      if (!row_n && !we_n && !dq_oe_n) begin
         if (!hi_n) mem[addr[7:0]][15:8] <= dq_out[15:8];
         if (!lo_n) mem[addr[7:0]][7:0] <= dq_out[7:0];
      end
      if (!oe_n) last <= mem[addr[7:0]];
   end
   assign dq_in = !oe_n ? mem[addr[7:0]] : ~last;
endmodule

/* File: dv/testbench.sv */
// Purpose: writes both banks, enables the panel and checks the scan stream
// Assumes: display fetch starts at word zero of both banks
// Notes: lines are counted by latch pulse rises; shift clock rises between latch pulses give each line's length
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, g, e); end end
module testbench;
   import dpd_pkg::*;
   logic mclk = 1'b0, reset_n = 1'b0, pixel_input_clock = 1'b0, wr_valid = 1'b0, wr_bank = 1'b0;
   logic power_request_in = 1'b0, control_request_in = 1'b0, wr_ready, sh_d = 1'b0, ll_d = 1'b0;
   logic line_latch_pulse, panel_shift_clock, frame_start_marker, panel_disable_n, panel_power_enable;
   logic [1:0] mode_select = 2'h0, wr_be = 2'h0;
   logic [WADDR_W-1:0] wr_addr = '0;
   logic [DATA_W-1:0] wr_data = '0, bank_a_data_in, bank_a_data_out, bank_b_data_in, bank_b_data_out, wa, wb, wc;
   logic [SCAN_W-1:0] upper_half_data, lower_half_data;
   logic [ADDR_W-1:0] bank_a_addr, bank_b_addr;
   logic panel_contrast_enable, bank_a_data_oe_n, bank_a_row_strobe_n, bank_a_hi_col_strobe_n, bank_a_lo_col_strobe_n;
   logic bank_a_out_en_n, bank_a_write_strobe_n, bank_b_data_oe_n, bank_b_row_strobe_n, bank_b_hi_col_strobe_n;
   logic bank_b_lo_col_strobe_n, bank_b_out_en_n, bank_b_write_strobe_n;
   logic [31:0] seed = 32'h000082bc;
   logic [23:0] expq [$];
   logic [23:0] exp_w;
   int error_cnt = 0, checked = 0, shifts = 0, lines = 0;
   dstn_panel_and_dram_port dstn_panel_and_dram_port_inst (.*);
   dpd_dram_model bank_a_model (.mclk(mclk), .addr(bank_a_addr), .dq_out(bank_a_data_out),
      .dq_oe_n(bank_a_data_oe_n), .row_n(bank_a_row_strobe_n), .hi_n(bank_a_hi_col_strobe_n),
      .lo_n(bank_a_lo_col_strobe_n), .oe_n(bank_a_out_en_n), .we_n(bank_a_write_strobe_n), .dq_in(bank_a_data_in));
   dpd_dram_model bank_b_model (.mclk(mclk), .addr(bank_b_addr), .dq_out(bank_b_data_out),
      .dq_oe_n(bank_b_data_oe_n), .row_n(bank_b_row_strobe_n), .hi_n(bank_b_hi_col_strobe_n),
      .lo_n(bank_b_lo_col_strobe_n), .oe_n(bank_b_out_en_n), .we_n(bank_b_write_strobe_n), .dq_in(bank_b_data_in));
   always #5 mclk = ~mclk;
   always #80 pixel_input_clock = ~pixel_input_clock;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic close_out();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic bank, input logic [1:0] be, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge mclk);
      wr_valid = 1'b1;
      wr_bank = bank;
      wr_be = be;
      wr_data = d;
      do begin @(negedge mclk); n++; end while (wr_ready !== 1'b1 && n < 400);
      @(negedge mclk);
      wr_valid = 1'b0;
      `CHK(n < 400, 1'b1)
   endtask
   always @(negedge mclk) begin
      sh_d <= panel_shift_clock;
      ll_d <= line_latch_pulse;
      if (reset_n !== 1'b1) shifts = 0;
      if (panel_shift_clock === 1'b1 && !sh_d) begin
         shifts++;
         if (expq.size() > 0) begin
            exp_w = expq.pop_front();
            `CHK({upper_half_data, lower_half_data}, exp_w)
         end
      end
      if (line_latch_pulse === 1'b1 && !ll_d) begin
         `CHK(shifts, LINE_WORDS)
         `CHK({upper_half_data, lower_half_data, frame_start_marker}, 25'h0)
         shifts = 0;
         lines++;
      end
   end
   initial begin
      repeat (12) @(negedge mclk);
      `CHK({bank_a_row_strobe_n, bank_a_write_strobe_n, bank_b_row_strobe_n, bank_b_out_en_n}, 4'hf)
      reset_n = 1'b1;
      seed = xs(seed);
      wa = seed[15:0];
      seed = xs(seed);
      wb = seed[15:0];
      wc = seed[31:16];
      // frame buffer is loaded while the panel is still off, so fetch starts at word zero
      wr(1'b0, BE_BOTH, wa);
      wr(1'b1, BE_BOTH, wb);
      wr(1'b0, 2'h1, wc);
      mode_select = 2'h2;
      expq.push_back({wa[11:8], wc[7:0], wb[11:0]});
      repeat (3 * LINE_WORDS - 1) expq.push_back(24'h0);
      for (int i = 0; i < 4; i++) begin
         power_request_in = i[0];
         control_request_in = i[1];
         repeat (8) @(negedge mclk);
         `CHK(panel_power_enable, i[0])
         `CHK({panel_contrast_enable, panel_disable_n}, {2{i[0] & i[1]}})
      end
      wait (lines >= 3);
      `CHK(expq.size(), 0)
      // mid-run reset cuts the line; scan and fetch restart at word zero in TFT mode, low byte of each word only
      reset_n = 1'b0;
      mode_select = 2'h1;
      repeat (4) @(negedge mclk);
      `CHK({panel_shift_clock, line_latch_pulse, panel_disable_n, bank_b_write_strobe_n, bank_a_out_en_n}, 5'h03)
      expq.push_back({4'h0, wc[7:0], 4'h0, wb[7:0]});
      repeat (3 * LINE_WORDS - 1) expq.push_back(24'h0);
      reset_n = 1'b1;
      wait (lines >= 6);
      `CHK(expq.size(), 0)
      `CHK({panel_power_enable, panel_contrast_enable, panel_disable_n}, 3'h7)
      close_out();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      error_cnt++;
      close_out();
   end
endmodule
